/* src/lsc_core.v */
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "lsc_regs.vh"
// Sync control: pin routing, receive gate, break timer, compare, interrupt
module lsc_core
#(
    parameter TW = 16,
    parameter BRK_MIN = `LSC_BRK_MIN
)
(
    input wire ref_clk,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    input wire xcvr_rx,
    output wire xcvr_tx,
    input wire uart_tx,
    output wire uart_rx,
    input wire aux_pin_tx,
    output wire aux_pin_rx,
    output reg irq
);
    reg [15:0] ctrl;
    reg [4:0] stat;
    reg [TW-1:0] brk_timer;
    reg [TW-1:0] sbt;
    reg [TW-1:0] cmp;
    reg [3:0] fall_cnt;
    reg brk_run;
    reg [2:0] state;
    reg [2:0] next_state;

    // Status bit update: a hardware event wins over a software clear
    function w1c_next;
        input set;
        input cur;
        input clr;
        begin
            w1c_next = set | (cur & ~clr);
        end
    endfunction

    // Write strobe aimed at one register offset
    function wr_at;
        input strobe;
        input [3:0] at;
        input [3:0] a;
        begin
            wr_at = strobe && at == a;
        end
    endfunction

    wire line_q;
    wire rise;
    wire fall;
    wire test = ctrl[`LSC_CTL_TEST];
    wire gate = ctrl[`LSC_CTL_GATE];
    wire bit_serial_device_bus = ctrl[`LSC_CTL_MODE];
    wire en = ctrl[`LSC_CTL_EN];
    wire st_wr = wr_at(wr, addr, `LSC_ADDR_STAT);
    localparam S_IDLE = 3'b001;
    localparam S_SYNC = 3'b010;
    localparam S_DATA = 3'b100;

    lsc_edge u_edge
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .line_in(xcvr_rx),
        .line_q(line_q),
        .rise(rise),
        .fall(fall)
    );

    // ========================================
    // Pin routing
    // Test mode cuts the UART off both ways; aux pin owns the line
    assign xcvr_tx = test ? aux_pin_tx : uart_tx;
    assign aux_pin_rx = test ? xcvr_rx : 1'b1;
    // Enabled LIN mode holds UART input idle until break and sync seen, set gate or not; clear gate
    // lets the line through once the header is done as well
    assign uart_rx = test ? 1'b1 :
        (!bit_serial_device_bus && en && state != S_DATA) ? 1'b1 : line_q;

    // ========================================
    // Break timer events
    wire brk_end = brk_run && rise;
    wire brk_ok = brk_end && brk_timer >= BRK_MIN;
    // Any short low pulse in LIN mode counts as a break error, also inside
    // a frame; software has to ignore the flag once the header is done
    wire brk_err = brk_end && !brk_ok && !bit_serial_device_bus;
    // Write mode with gate clear suppresses rising edge break interrupt
    wire rise_ev = brk_end && (!bit_serial_device_bus || gate);
    // Compare only while the unit runs; a held timer would match forever
    wire cmp_ev = en && ctrl[`LSC_CTL_CMPEN] && sbt == cmp;
    wire sync_done = state == S_SYNC && next_state == S_DATA;

    // Header tracker: break, then five falls of the sync byte
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
                if (brk_ok && !bit_serial_device_bus)
                    next_state = S_SYNC;
            S_SYNC:
                if (fall_cnt == 4'h5 && rise)
                    next_state = S_DATA;
            S_DATA:
                if (fall && !en)
                    next_state = S_IDLE;
            default:
                next_state = S_IDLE;
        endcase
        if (!en || bit_serial_device_bus)
            next_state = S_IDLE;
    end

    // Header state register
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // Break timer restarts on every fall while enabled and freezes on the rise, so
    // software can read back the width of the last low pulse in any mode
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brk_run <= 1'b0;
            brk_timer <= {TW{1'b0}};
        end
        else if (fall && en)
        begin
            brk_run <= 1'b1;
            brk_timer <= {TW{1'b0}};
        end
        else if (brk_end)
            brk_run <= 1'b0;
        else if (brk_run)
            brk_timer <= brk_timer + 1'b1;
    end

    // Bit timer restarts each falling edge for compare timing; held at
    // zero while the unit is off
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sbt <= {TW{1'b0}};
        else if (fall || !en)
            sbt <= {TW{1'b0}};
        else
            sbt <= sbt + 1'b1;
    end

    // Falls seen inside the sync byte; cleared outside the sync state
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            fall_cnt <= 4'h0;
        else if (state != S_SYNC)
            fall_cnt <= 4'h0;
        else if (fall)
            fall_cnt <= fall_cnt + 1'b1;
    end

    // ========================================
    // Registers; hardware set beats software clear
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `LSC_CTL_RESET;
            cmp <= {TW{1'b1}};
            stat <= 5'h00;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_at(wr, addr, `LSC_ADDR_CTRL))
                ctrl <= wdata;
            if (wr_at(wr, addr, `LSC_ADDR_CMP))
                cmp <= wdata[TW-1:0];
            stat[`LSC_ST_BRK] <= w1c_next(brk_ok,
                stat[`LSC_ST_BRK], st_wr & wdata[`LSC_ST_BRK]);
            stat[`LSC_ST_SYNC] <= w1c_next(sync_done,
                stat[`LSC_ST_SYNC], st_wr & wdata[`LSC_ST_SYNC]);
            stat[`LSC_ST_ERR] <= w1c_next(brk_err,
                stat[`LSC_ST_ERR], st_wr & wdata[`LSC_ST_ERR]);
            stat[`LSC_ST_CMP] <= w1c_next(cmp_ev,
                stat[`LSC_ST_CMP], st_wr & wdata[`LSC_ST_CMP]);
            stat[`LSC_ST_RISE] <= w1c_next(rise_ev,
                stat[`LSC_ST_RISE], st_wr & wdata[`LSC_ST_RISE]);
            // One-cycle interrupt pulse from enabled events; two events in
            // adjacent cycles give two pulses back to back
            irq <= (brk_err && !ctrl[`LSC_CTL_ERRDIS])
                || cmp_ev
                || (rise_ev && ctrl[`LSC_CTL_BRKEN]);
        end
    end

    // Read data stand one cycle after the strobe and are zero otherwise
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                `LSC_ADDR_CTRL: rdata <= ctrl;
                `LSC_ADDR_STAT: rdata <= {11'h000, stat};
                `LSC_ADDR_BRK: rdata <= brk_timer;
                `LSC_ADDR_SBT: rdata <= sbt;
                `LSC_ADDR_CMP: rdata <= cmp;
                default: rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end
endmodule

/* src/lsc_edge.v */
`timescale 1ns/1ns
// Registered line sampler with rise and fall pulses
module lsc_edge
(
    input wire ref_clk,
    input wire rst_n,
    input wire line_in,
    output reg line_q,
    output wire rise,
    output wire fall
);
    // Idle bus level is high, so reset to high avoids a false edge
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            line_q <= 1'b1;
        else
            line_q <= line_in;
    end
    assign rise = line_in & ~line_q;
    assign fall = ~line_in & line_q;
endmodule

/* src/lsc_regs.vh */
// Operation
// - Break timer error interrupt is enabled when its disable bit is 0.
// - Test mode bit 1 routes aux pins straight to the transceiver.
// - Test mode bit 0 connects transceiver directly to the UART.
// - UART mode, gate 1: UART receive held high until break and sync.
// - UART mode, gate 0: receive line passed to UART after break and sync.
// - Bus write mode, gate 0: no break interrupt on bus rising edge.
// - Break interrupt left enabled in write mode fires on bus release; the code fires it there only with gate 1.
// - Break timer stops counting on a bus rising edge in both bus modes.
// - Mode bit 6 selects bit-serial bus when 1, LIN when 0.
// - Compare enable bit 5 raises interrupt and flag on timer match.
`ifndef LSC_REGS_VH
`define LSC_REGS_VH
// ========================================
// Register offsets
`define LSC_ADDR_CTRL 4'h0
`define LSC_ADDR_STAT 4'h1
`define LSC_ADDR_BRK 4'h2
`define LSC_ADDR_SBT 4'h3
`define LSC_ADDR_CMP 4'h4
// ========================================
// Control field positions
`define LSC_CTL_ERRDIS 10
`define LSC_CTL_TEST 9
`define LSC_CTL_GATE 8
`define LSC_CTL_MODE 6
`define LSC_CTL_CMPEN 5
`define LSC_CTL_BRKEN 4
`define LSC_CTL_EN 2
`define LSC_CTL_RESET 16'h0400
// ========================================
// Status field positions
`define LSC_ST_BRK 0
`define LSC_ST_SYNC 1
`define LSC_ST_ERR 2
`define LSC_ST_CMP 3
`define LSC_ST_RISE 4
// ========================================
// Timing
`define LSC_CLK_MHZ 50
`define LSC_BIT_MIN_US 11
`define LSC_BRK_BITS 11
// Shortest low pulse accepted as a break, in clocks
`define LSC_BRK_MIN 16'h0200
`endif

/* verif/lsc_core_properties.sv */
`timescale 1ns/1ns
// ==========
// Port checker
module lsc_core_checker
(
    input wire ref_clk,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    input wire xcvr_rx,
    input wire xcvr_tx,
    input wire uart_tx,
    input wire uart_rx,
    input wire aux_pin_tx,
    input wire aux_pin_rx,
    input wire irq
);
    reg [15:0] ctl;
    // Control shadow, lands on the same edge as the block's own copy
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl <= 16'h0400;
        else if (wr && addr == 4'h0)
            ctl <= wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_test_tx_aux: assert property (ctl[9]
        |-> xcvr_tx == aux_pin_tx)
        else $error("tx not from aux pin");
    chk_norm_tx_uart: assert property (!ctl[9] |-> xcvr_tx == uart_tx)
        else $error("tx not from uart");
    chk_test_rx_aux: assert property (ctl[9] |-> aux_pin_rx == xcvr_rx)
        else $error("aux rx not from line");
    chk_test_uart_idle: assert property (ctl[9] |-> uart_rx)
        else $error("uart rx not held in test");
    chk_rx_pass_delay: assert property (!ctl[9] && !ctl[2]
        |-> uart_rx == $past(xcvr_rx))
        else $error("uart rx not one cycle behind line");
    chk_bsd_no_irq: assert property (ctl[6] && !ctl[8] && !ctl[5]
        |-> ##1 !irq)
        else $error("break interrupt with gate clear");
    chk_rd_unmapped: assert property (rd && addr > 4'h4 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_irq_one_cycle: assert property (irq |=> !irq)
        else $error("interrupt longer than a pulse");
    cover property (ctl[9] && !aux_pin_tx);
    cover property (ctl[6] && irq);
    cover property (ctl[2] && !ctl[6] && irq);
endmodule
bind lsc_core lsc_core_checker chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .xcvr_rx(xcvr_rx), .xcvr_tx(xcvr_tx), .uart_tx(uart_tx),
    .uart_rx(uart_rx), .aux_pin_tx(aux_pin_tx), .aux_pin_rx(aux_pin_rx),
    .irq(irq));

/* verif/lsc_core_tb.sv */
`timescale 1ns/1ns
module lsc_core_tb;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg uart_tx = 1'b1;
    reg aux_pin_tx = 1'b1;
    wire [15:0] rdata;
    wire xcvr_rx, xcvr_tx, uart_rx, aux_pin_rx, irq;
    integer mismatches = 0;
    integer n_checks = 0;
    integer irqs = 0;
    integer lows = 0;
    integer i, k, n;
    reg [15:0] v, t;
    // ==========
    // Clock, design, far side
    always #10 ref_clk = ~ref_clk;
    lsc_core #(.BRK_MIN(16'h0020)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .xcvr_rx(xcvr_rx), .xcvr_tx(xcvr_tx), .uart_tx(uart_tx),
        .uart_rx(uart_rx), .aux_pin_tx(aux_pin_tx),
        .aux_pin_rx(aux_pin_rx), .irq(irq));
    lsc_lin_master m (.ref_clk(ref_clk), .line(xcvr_rx));
    // Count interrupt pulses and low cycles reaching the UART
    always @(posedge ref_clk)
    begin
        irqs = irqs + (irq === 1'b1);
        lows = lows + (uart_rx !== 1'b1);
    end
    task wr_reg(input [3:0] a, input [15:0] d);
    begin
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    end
    endtask
    // Data stand only in the cycle after the strobe
    task rd_reg(input [3:0] a, output [15:0] d);
    begin
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    end
    endtask
    task check(input [95:0] what, input [15:0] seen, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
        end
    end
    endtask
    task complete_run;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // Hang guard, well past the fewer than a thousand cycles the tests need
    initial
    begin
        #400000;
        mismatches = mismatches + 1;
        complete_run;
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(4'h0, v);
        check("ctrl reset", v, 16'h0400);
        rd_reg(4'h9, v);
        check("unmapped", v, 16'h0000);
        for (i = 0; i < 2; i = i + 1)
        begin
            wr_reg(4'h0, i ? 16'h0504 : 16'h0404);
            k = lows;
            m.header(120);
            check("rx gated", 16'(lows - k), 16'h0000);
            k = lows;
            m.send_byte(8'h00);
            check("rx passed", 16'(lows > k), 16'h0001);
            rd_reg(4'h1, v);
            check("sync done", v & 16'h0002, 16'h0002);
            wr_reg(4'h1, 16'h001f);
            wr_reg(4'h0, i ? 16'h0004 : 16'h0404);
            k = irqs;
            // Short low pulse alone; sync bits after it would add errors
            m.drive(1'b0, 16);
            m.drive(1'b1, 10);
            check("brk err irq", 16'(irqs - k), 16'(i));
            wr_reg(4'h0, 16'h0400);
            wr_reg(4'h1, 16'h001f);
            // Break interrupt enabled; gate clear first, then gate set
            wr_reg(4'h0, 16'h0454 | 16'(i << 8));
            k = irqs;
            m.drive(1'b0, 40);
            m.drive(1'b1, 10);
            check("bsd irq", 16'(irqs - k), 16'(i));
            rd_reg(4'h2, v);
            rd_reg(4'h2, t);
            check("brk stop", t, v);
            check("brk width", 16'(v >= 38 && v <= 42), 16'h0001);
        end
        wr_reg(4'h4, 16'h0008);
        wr_reg(4'h0, 16'h0464);
        k = irqs;
        m.drive(1'b0, 1);
        n = 0;
        // Software holds the bus low until the compare interrupt arrives
        while (irq !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk);
            #1 n = n + 1;
        end
        m.drive(1'b1, 10);
        check("cmp irq", 16'(irqs - k), 16'h0001);
        check("cmp wait", 16'(n < 40), 16'h0001);
        rd_reg(4'h1, v);
        check("cmp flag", v & 16'h0008, 16'h0008);
        rd_reg(4'h2, v);
        check("pulse width", 16'(v >= 8 && v <= 12), 16'h0001);
        for (i = 0; i < 8; i = i + 1)
        begin
            // Aux pin functions are taken as already set up here
            if (i == 0)
                wr_reg(4'h0, 16'h0600);
            if (i == 4)
                wr_reg(4'h0, 16'h0400);
            @(posedge ref_clk);
            aux_pin_tx <= i[0];
            uart_tx <= ~i[0];
            m.drive(i[1], 1);
            t = {15'h0, i < 4 ? i[0] : ~i[0]};
            v = {15'h0, i < 4 ? i[1] : 1'b1};
            #1 check("tx", {15'h0, xcvr_tx}, t);
            check("aux rx", {15'h0, aux_pin_rx}, v);
        end
        complete_run;
    end
endmodule

/* verif/lsc_lin_master.sv */
`timescale 1ns/1ns
// ==========
// Bus master seen through the transceiver; idle high from the pull-up
module lsc_lin_master
#(
    parameter BIT = 8
)
(
    input wire ref_clk,
    output reg line
);
    integer j;
    initial line = 1'b1;
    // Hold a level n clocks, changing just after an edge
    task drive(input lvl, input integer n);
    begin
        @(posedge ref_clk);
        line <= lvl;
        repeat (n - 1) @(posedge ref_clk);
    end
    endtask
    // Start bit, LSB first, stop bit
    task send_byte(input [7:0] b);
    begin
        drive(1'b0, BIT);
        for (j = 0; j < 8; j = j + 1)
            drive(b[j], BIT);
        drive(1'b1, BIT);
    end
    endtask
    // Break of n clocks, delimiter, sync byte, idle
    task header(input integer n);
    begin
        drive(1'b0, n);
        drive(1'b1, BIT);
        send_byte(8'h55);
        drive(1'b1, 2 * BIT);
    end
    endtask
endmodule
